// [rtl/scg_defs.svh]
// Register offsets, field positions, reset values for sleep clock gating.
// Assumes inclusion by the package, scg_top and the testbench.
`ifndef SCG_DEFS_SVH
`define SCG_DEFS_SVH

`define SCG_ADDR_W          12
`define SCG_OFF_RUN_GATE    12'h100
`define SCG_OFF_SLEEP_GATE  12'h110
`define SCG_OFF_DEEP_GATE   12'h120
`define SCG_OFF_CFG         12'h140
`define SCG_OFF_INT_STAT    12'h144
`define SCG_OFF_INT_MASK    12'h148
`define SCG_OFF_FLT_ADDR    12'h14c
`define SCG_BIT_KEEPER      6
`define SCG_BIT_WDOG        3
`define SCG_BIT_AUTO_SEL    0
`define SCG_GATE_MASK       32'h0000_0048
`define SCG_GATE_RESET      32'h0000_0040
`define SCG_INT_FAULT       0
`define SCG_INT_UNMAPPED    1
`define SCG_INT_MASK_ALL    32'h0000_0003

`endif

// [rtl/scg_pkg.sv]
// Types shared by the sleep clock gating block.
// Assumes scg_defs.svh is on the include path.
`default_nettype none
`include "scg_defs.svh"

package scg_pkg;

    typedef enum logic [1:0] {
        SCG_MODE_RUN,
        SCG_MODE_SLEEP,
        SCG_MODE_DEEP
    } scg_mode_t;

    typedef struct packed {
        logic                    wr;
        logic                    rd;
        logic [`SCG_ADDR_W-1:0]  addr;
        logic [31:0]             wdata;
    } scg_bus_req_t;

    typedef struct packed {
        logic keeper;
        logic wdog;
    } scg_gates_t;

    typedef struct packed {
        logic valid;
        logic wr;
        logic unit;
    } scg_periph_req_t;

endpackage

`default_nettype wire

// [rtl/scg_fault_check.sv]
// Fault check for accesses aimed at gated peripheral units.
// Assumes access request arrives as a one-cycle pulse; answers next cycle.
`timescale 1ns/10ps
`default_nettype none

module scg_fault_check
    import scg_pkg::*;
(
    input  wire logic            clk_sys,
    input  wire logic            rst,
    input  wire scg_periph_req_t preq,
    input  wire scg_gates_t      gates,
    output logic                 ok,
    output logic                 fault
);
    import scg_pkg::*;

    typedef struct packed {
        logic ok;
        logic fault;
    } scg_fc_state_t;

    scg_fc_state_t s_q;
    scg_fc_state_t s_d;

    function automatic logic unit_on(input logic unit, input scg_gates_t g);
        unit_on = unit ? g.wdog : g.keeper;
    endfunction

    always_comb begin
        s_d       = '0;
        s_d.ok    = preq.valid && unit_on(preq.unit, gates);
        s_d.fault = preq.valid && !unit_on(preq.unit, gates);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign ok    = s_q.ok;
    assign fault = s_q.fault;

    fault_gated_a: assert property (@(posedge clk_sys) disable iff (rst)
        preq.valid && !unit_on(preq.unit, gates) |=> fault && !ok)
        else $error("access to gated unit not faulted");

    pass_open_a: assert property (@(posedge clk_sys) disable iff (rst)
        preq.valid && unit_on(preq.unit, gates) |=> ok && !fault)
        else $error("access to clocked unit faulted");

endmodule

`default_nettype wire

// [rtl/scg_top.sv]
// Sleep / deep-sleep clock gating control with register port and fault check.
// Assumes a synchronous register port, synchronous mode inputs, one clock.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "scg_defs.svh"

module scg_top
    import scg_pkg::*;
(
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    input  wire logic [`SCG_ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]            reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic [31:0]                 reg_rdata,
    input  wire logic                   sleep_req,
    input  wire logic                   deep_sleep_req,
    input  wire logic                   periph_valid,
    input  wire logic                   periph_wr,
    input  wire logic                   periph_unit,
    output logic                        periph_ok,
    output logic                        periph_fault,
    output logic                        low_power_keeper_clk_en,
    output logic                        watchdog_clk_en,
    output logic                        irq
);
    import scg_pkg::*;

    // =========================================================
    // State
    typedef struct packed {
        logic [31:0] run_gate_reg;
        logic [31:0] sleep_gate_reg;
        logic [31:0] deep_sleep_gate_reg;
        logic        auto_clock_gating_sel;
        logic [31:0] int_stat;
        logic [31:0] int_mask;
        logic        flt_unit;
        logic        flt_wr;
        logic [31:0] rdata;
        scg_mode_t   mode;
        scg_gates_t  gates;
        logic        irq;
    } scg_state_t;

    scg_state_t      s_q;
    scg_state_t      s_d;
    scg_bus_req_t    bus;
    scg_periph_req_t preq;
    logic            fc_ok;
    logic            fc_fault;

    assign bus  = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};
    assign preq = '{valid: periph_valid, wr: periph_wr, unit: periph_unit};

    // =========================================================
    // Helpers
    function automatic logic [31:0] gate_write(input logic [31:0] v);
        gate_write = v & `SCG_GATE_MASK;
    endfunction

    function automatic scg_gates_t gates_of(input logic [31:0] r);
        gates_of = '{keeper: r[`SCG_BIT_KEEPER],
                     wdog:   r[`SCG_BIT_WDOG]};
    endfunction

    function automatic logic known_addr(input logic [`SCG_ADDR_W-1:0] a);
        known_addr = (a == `SCG_OFF_RUN_GATE) || (a == `SCG_OFF_SLEEP_GATE)
                  || (a == `SCG_OFF_DEEP_GATE) || (a == `SCG_OFF_CFG)
                  || (a == `SCG_OFF_INT_STAT) || (a == `SCG_OFF_INT_MASK)
                  || (a == `SCG_OFF_FLT_ADDR);
    endfunction

    // =========================================================
    // Next state
    always_comb begin
        s_d       = s_q;
        s_d.rdata = '0;

        // Register writes
        if (bus.wr) begin
            unique case (bus.addr)
                `SCG_OFF_RUN_GATE:   s_d.run_gate_reg        = gate_write(bus.wdata);
                `SCG_OFF_SLEEP_GATE: s_d.sleep_gate_reg      = gate_write(bus.wdata);
                `SCG_OFF_DEEP_GATE:  s_d.deep_sleep_gate_reg = gate_write(bus.wdata);
                `SCG_OFF_CFG:        s_d.auto_clock_gating_sel = bus.wdata[`SCG_BIT_AUTO_SEL];
                `SCG_OFF_INT_STAT:   s_d.int_stat = s_q.int_stat & ~bus.wdata;
                `SCG_OFF_INT_MASK:   s_d.int_mask = bus.wdata & `SCG_INT_MASK_ALL;
                default: ;
            endcase
        end

        // Register reads, data one cycle later
        if (bus.rd) begin
            unique case (bus.addr)
                `SCG_OFF_RUN_GATE:   s_d.rdata = s_q.run_gate_reg;
                `SCG_OFF_SLEEP_GATE: s_d.rdata = s_q.sleep_gate_reg;
                `SCG_OFF_DEEP_GATE:  s_d.rdata = s_q.deep_sleep_gate_reg;
                `SCG_OFF_CFG:        s_d.rdata = {31'h0, s_q.auto_clock_gating_sel};
                `SCG_OFF_INT_STAT:   s_d.rdata = s_q.int_stat;
                `SCG_OFF_INT_MASK:   s_d.rdata = s_q.int_mask;
                `SCG_OFF_FLT_ADDR:   s_d.rdata = {30'h0, s_q.flt_wr, s_q.flt_unit};
                default:             s_d.rdata = '0;
            endcase
        end

        // Sticky events; set wins over clear
        if ((bus.wr || bus.rd) && !known_addr(bus.addr)) begin
            s_d.int_stat[`SCG_INT_UNMAPPED] = 1'b1;
        end
        if (preq.valid && !(preq.unit ? s_q.gates.wdog : s_q.gates.keeper)) begin
            s_d.int_stat[`SCG_INT_FAULT] = 1'b1;
            s_d.flt_unit = preq.unit;
            s_d.flt_wr   = preq.wr;
        end

        // Power mode; deep sleep takes precedence
        if (deep_sleep_req) begin
            s_d.mode = SCG_MODE_DEEP;
        end else if (sleep_req) begin
            s_d.mode = SCG_MODE_SLEEP;
        end else begin
            s_d.mode = SCG_MODE_RUN;
        end

        // Active gate selection
        if (!s_d.auto_clock_gating_sel) begin
            s_d.gates = gates_of(s_d.run_gate_reg);
        end else begin
            unique case (s_d.mode)
                SCG_MODE_SLEEP: s_d.gates = gates_of(s_d.sleep_gate_reg);
                SCG_MODE_DEEP:  s_d.gates = gates_of(s_d.deep_sleep_gate_reg);
                default:        s_d.gates = gates_of(s_d.run_gate_reg);
            endcase
        end

        s_d.irq = |(s_d.int_stat & s_d.int_mask);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_q                       <= '0;
            s_q.run_gate_reg          <= `SCG_GATE_RESET;
            s_q.sleep_gate_reg        <= `SCG_GATE_RESET;
            s_q.deep_sleep_gate_reg   <= `SCG_GATE_RESET;
            s_q.gates.keeper          <= 1'b1;
            s_q.mode                  <= SCG_MODE_RUN;
        end else begin
            s_q <= s_d;
        end
    end

    // =========================================================
    // Fault check
    scg_fault_check u_fault (
        .clk_sys (clk_sys),
        .rst     (rst),
        .preq    (preq),
        .gates   (s_q.gates),
        .ok      (fc_ok),
        .fault   (fc_fault)
    );

    assign reg_rdata               = s_q.rdata;
    assign low_power_keeper_clk_en = s_q.gates.keeper;
    assign watchdog_clk_en         = s_q.gates.wdog;
    assign irq                     = s_q.irq;
    assign periph_ok               = fc_ok;
    assign periph_fault            = fc_fault;

    // =========================================================
    // Checks
    sequence sleep_write_s;
        bus.wr && bus.addr == `SCG_OFF_SLEEP_GATE;
    endsequence

    sequence deep_write_s;
        bus.wr && bus.addr == `SCG_OFF_DEEP_GATE;
    endsequence

    sequence gate_read_s;
        bus.rd && (bus.addr == `SCG_OFF_RUN_GATE || bus.addr == `SCG_OFF_SLEEP_GATE
            || bus.addr == `SCG_OFF_DEEP_GATE);
    endsequence

    sequence unmapped_s;
        (bus.wr || bus.rd) && !known_addr(bus.addr);
    endsequence

    // Access aimed at a unit whose gate is currently off
    sequence gated_access_s;
        preq.valid && !(preq.unit ? watchdog_clk_en : low_power_keeper_clk_en);
    endsequence

    reset_vals_a: assert property (@(posedge clk_sys)
        $fell(rst) |-> s_q.sleep_gate_reg == 32'h40 && s_q.deep_sleep_gate_reg == 32'h40)
        else $error("gate registers wrong after reset");

    keeper_reset_a: assert property (@(posedge clk_sys)
        $fell(rst) |-> low_power_keeper_clk_en && !watchdog_clk_en)
        else $error("keeper gate not set after reset");

    wdog_field_a: assert property (@(posedge clk_sys) disable iff (rst)
        sleep_write_s |=> s_q.sleep_gate_reg[3] == $past(bus.wdata[3]))
        else $error("watchdog gate bit not written");

    reserved_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
        gate_read_s |=> (reg_rdata & ~`SCG_GATE_MASK) == 32'h0)
        else $error("reserved gate bits read nonzero");

    sleep_apply_a: assert property (@(posedge clk_sys) disable iff (rst)
        s_q.auto_clock_gating_sel && s_q.mode == SCG_MODE_SLEEP
        |-> watchdog_clk_en == s_q.sleep_gate_reg[3])
        else $error("sleep gates not applied in sleep");

    deep_apply_a: assert property (@(posedge clk_sys) disable iff (rst)
        s_q.auto_clock_gating_sel && s_q.mode == SCG_MODE_DEEP
        |-> low_power_keeper_clk_en == s_q.deep_sleep_gate_reg[6])
        else $error("deep sleep gates not applied");

    auto_off_a: assert property (@(posedge clk_sys) disable iff (rst)
        !s_q.auto_clock_gating_sel |-> watchdog_clk_en == s_q.run_gate_reg[3]
            && low_power_keeper_clk_en == s_q.run_gate_reg[6])
        else $error("run gates not kept without auto select");

    fault_top_a: assert property (@(posedge clk_sys) disable iff (rst)
        periph_valid && !periph_unit && !low_power_keeper_clk_en |=> periph_fault)
        else $error("keeper access while gated not faulted");

    clk_follow_a: assert property (@(posedge clk_sys) disable iff (rst)
        deep_sleep_req && s_q.auto_clock_gating_sel && !(bus.wr)
        |=> watchdog_clk_en == s_q.deep_sleep_gate_reg[3])
        else $error("watchdog enable does not follow deep sleep gate");

    irq_level_a: assert property (@(posedge clk_sys) disable iff (rst)
        irq == |(s_q.int_stat & s_q.int_mask))
        else $error("interrupt not level of masked status");

    // =========================================================
    // Register port checks
    rdata_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
        !bus.rd |=> reg_rdata == 32'h0)
        else $error("read data not zero outside a read");

    sleep_rd_a: assert property (@(posedge clk_sys) disable iff (rst)
        bus.rd && bus.addr == `SCG_OFF_SLEEP_GATE |=> reg_rdata == $past(s_q.sleep_gate_reg))
        else $error("sleep gate register read back wrong");

    deep_rd_a: assert property (@(posedge clk_sys) disable iff (rst)
        bus.rd && bus.addr == `SCG_OFF_DEEP_GATE |=> reg_rdata == $past(s_q.deep_sleep_gate_reg))
        else $error("deep sleep gate register read back wrong");

    run_rd_a: assert property (@(posedge clk_sys) disable iff (rst)
        bus.rd && bus.addr == `SCG_OFF_RUN_GATE |=> reg_rdata == $past(s_q.run_gate_reg))
        else $error("run gate register read back wrong");

    cfg_rd_a: assert property (@(posedge clk_sys) disable iff (rst)
        bus.rd && bus.addr == `SCG_OFF_CFG |=> reg_rdata == {31'h0, $past(s_q.auto_clock_gating_sel)})
        else $error("auto select read back wrong");

    keeper_wr_a: assert property (@(posedge clk_sys) disable iff (rst)
        sleep_write_s |=> s_q.sleep_gate_reg[`SCG_BIT_KEEPER] == $past(bus.wdata[`SCG_BIT_KEEPER]))
        else $error("sleep keeper gate bit not written");

    deep_keeper_a: assert property (@(posedge clk_sys) disable iff (rst)
        deep_write_s |=> s_q.deep_sleep_gate_reg[`SCG_BIT_KEEPER] == $past(bus.wdata[`SCG_BIT_KEEPER]))
        else $error("deep keeper gate bit not written");

    deep_wdog_a: assert property (@(posedge clk_sys) disable iff (rst)
        deep_write_s |=> s_q.deep_sleep_gate_reg[`SCG_BIT_WDOG] == $past(bus.wdata[`SCG_BIT_WDOG]))
        else $error("deep watchdog gate bit not written");

    gate_rsvd_a: assert property (@(posedge clk_sys) disable iff (rst)
        ((s_q.run_gate_reg | s_q.sleep_gate_reg | s_q.deep_sleep_gate_reg)
            & ~`SCG_GATE_MASK) == 32'h0)
        else $error("reserved gate bits held nonzero");

    mask_wr_a: assert property (@(posedge clk_sys) disable iff (rst)
        bus.wr && bus.addr == `SCG_OFF_INT_MASK |=> s_q.int_mask == ($past(bus.wdata) & `SCG_INT_MASK_ALL))
        else $error("interrupt mask not written");

    // =========================================================
    // Gate selection checks
    mode_deep_a: assert property (@(posedge clk_sys) disable iff (rst)
        deep_sleep_req |=> s_q.mode == SCG_MODE_DEEP)
        else $error("deep sleep request not taken");

    mode_sleep_a: assert property (@(posedge clk_sys) disable iff (rst)
        sleep_req && !deep_sleep_req |=> s_q.mode == SCG_MODE_SLEEP)
        else $error("sleep request not taken");

    mode_run_a: assert property (@(posedge clk_sys) disable iff (rst)
        !sleep_req && !deep_sleep_req |=> s_q.mode == SCG_MODE_RUN)
        else $error("run mode not taken");

    sleep_follow_a: assert property (@(posedge clk_sys) disable iff (rst)
        sleep_req && !deep_sleep_req && s_q.auto_clock_gating_sel && !bus.wr |=>
            low_power_keeper_clk_en == s_q.sleep_gate_reg[`SCG_BIT_KEEPER] && watchdog_clk_en == s_q.sleep_gate_reg[`SCG_BIT_WDOG])
        else $error("sleep gates not followed");

    run_follow_a: assert property (@(posedge clk_sys) disable iff (rst)
        !sleep_req && !deep_sleep_req |=>
            low_power_keeper_clk_en == s_q.run_gate_reg[`SCG_BIT_KEEPER] && watchdog_clk_en == s_q.run_gate_reg[`SCG_BIT_WDOG])
        else $error("run gates not applied while running");

    // =========================================================
    // Event checks
    unmapped_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
        unmapped_s |=> s_q.int_stat[`SCG_INT_UNMAPPED])
        else $error("unmapped access not flagged");

    fault_info_a: assert property (@(posedge clk_sys) disable iff (rst)
        gated_access_s |=> s_q.int_stat[`SCG_INT_FAULT]
            && s_q.flt_unit == $past(preq.unit) && s_q.flt_wr == $past(preq.wr))
        else $error("gated access not recorded");

    stat_w1c_a: assert property (@(posedge clk_sys) disable iff (rst)
        bus.wr && bus.addr == `SCG_OFF_INT_STAT && bus.wdata[`SCG_INT_FAULT] && !preq.valid
            |=> !s_q.int_stat[`SCG_INT_FAULT])
        else $error("fault status not cleared by writing one");

    ok_fault_excl_a: assert property (@(posedge clk_sys) disable iff (rst)
        !(periph_ok && periph_fault))
        else $error("access answered both ok and fault");

    idle_quiet_a: assert property (@(posedge clk_sys) disable iff (rst)
        !preq.valid |=> !periph_ok && !periph_fault)
        else $error("access answer without a request");

endmodule

`default_nettype wire

// [tb/scg_periph_model.sv]
// Stand-in for the gated units: a watchdog that ticks only while clocked.
// Assumes the access port of scg_top, answered one cycle after the request.
`timescale 1ns/10ps
`default_nettype none

module scg_periph_model (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        wdog_en,
    input  wire logic        ok,
    input  wire logic        fault,
    output logic             valid,
    output logic             wr,
    output logic             unit,
    output logic [15:0]      wdog_ticks
);
    initial begin
        valid = 1'b0;
        wr = 1'b0;
        unit = 1'b0;
    end

    always @(posedge clk_sys) begin
        if (rst)
            wdog_ticks <= 16'h0;
        else if (wdog_en)
            wdog_ticks <= wdog_ticks + 16'h1;
    end

    // Released qualifiers flip so a stale value is never mistaken for a hold
    task automatic access(input logic u, input logic w, output logic [1:0] ans);
        @(posedge clk_sys);
        valid <= 1'b1;
        unit <= u;
        wr <= w;
        @(posedge clk_sys);
        valid <= 1'b0;
        unit <= ~u;
        wr <= ~w;
        #1;
        ans = {ok, fault};
    endtask
endmodule

`default_nettype wire

// [tb/tb_top.sv]
// Testbench for scg_top: register port, mode inputs and gated unit accesses.
// Assumes scg_pkg and scg_defs.svh are compiled and on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "scg_defs.svh"

module tb_top;
    logic        clk_sys, rst, reg_wr, reg_rd, sleep_req, deep_sleep_req;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic        pv, pw, pu, ok, flt, kclk, wclk, irq;
    logic [15:0] ticks, t0;
    logic [1:0]  ans;
    int          bad_count, cmp_count, cyc;

    scg_top u_scg_top (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_req(sleep_req),
        .deep_sleep_req(deep_sleep_req), .periph_valid(pv), .periph_wr(pw), .periph_unit(pu),
        .periph_ok(ok), .periph_fault(flt), .low_power_keeper_clk_en(kclk), .watchdog_clk_en(wclk),
        .irq(irq));
    scg_periph_model u_scg_periph_model (.clk_sys(clk_sys), .rst(rst), .wdog_en(wclk), .ok(ok),
        .fault(flt), .valid(pv), .wr(pw), .unit(pu), .wdog_ticks(ticks));

    always #2.5 clk_sys = ~clk_sys;

    task automatic conclude;
        if (bad_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            bad_count++;
            conclude();
        end
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic wr32(input logic [11:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd32(input logic [11:0] a, input logic [31:0] e, input string n);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
        chk(n, e, d);
    endtask

    task automatic gates(input logic k, input logic w);
        repeat (3) @(posedge clk_sys);
        #1;
        chk("keeper_clk_en", {31'h0, k}, {31'h0, kclk});
        chk("watchdog_clk_en", {31'h0, w}, {31'h0, wclk});
    endtask

    task automatic acc(input logic u, input logic w, input logic [1:0] e);
        u_scg_periph_model.access(u, w, ans);
        chk("periph_answer", {30'h0, e}, {30'h0, ans});
    endtask

    initial begin
        {clk_sys, reg_wr, reg_rd, sleep_req, deep_sleep_req, cyc, bad_count, cmp_count} = '0;
        {reg_addr, reg_wdata} = '0;
        rst = 1'b1;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        rd32(`SCG_OFF_SLEEP_GATE, 32'h40, "sleep_reset");
        rd32(`SCG_OFF_DEEP_GATE, 32'h40, "deep_reset");
        gates(1'b1, 1'b0);
        wr32(`SCG_OFF_SLEEP_GATE, 32'hffffffff);
        rd32(`SCG_OFF_SLEEP_GATE, 32'h48, "sleep_rsvd");
        rd32(`SCG_OFF_DEEP_GATE, 32'h40, "deep_rmw");
        wr32(`SCG_OFF_DEEP_GATE, d & ~32'h40);
        rd32(`SCG_OFF_DEEP_GATE, 32'h0, "deep_clear");
        @(posedge clk_sys);
        sleep_req <= 1'b1;
        gates(1'b1, 1'b0);
        wr32(`SCG_OFF_CFG, 32'h1);
        rd32(`SCG_OFF_CFG, 32'h1, "cfg_auto");
        gates(1'b1, 1'b1);
        t0 = ticks;
        repeat (10) @(posedge clk_sys);
        #1;
        chk("wdog_ticks", 32'h0000000a, {16'h0, ticks - t0});
        @(posedge clk_sys);
        deep_sleep_req <= 1'b1;
        gates(1'b0, 1'b0);
        t0 = ticks;
        repeat (10) @(posedge clk_sys);
        #1;
        chk("wdog_stopped", 32'h0, {16'h0, ticks - t0});
        acc(1'b1, 1'b1, 2'b01);
        rd32(`SCG_OFF_FLT_ADDR, 32'h3, "fault_info");
        acc(1'b0, 1'b0, 2'b01);
        rd32(`SCG_OFF_FLT_ADDR, 32'h0, "fault_info0");
        rd32(`SCG_OFF_INT_STAT, 32'h1, "stat_fault");
        chk("irq_masked", 32'h0, {31'h0, irq});
        wr32(`SCG_OFF_INT_MASK, 32'h3);
        rd32(`SCG_OFF_INT_MASK, 32'h3, "mask");
        chk("irq_on", 32'h1, {31'h0, irq});
        wr32(`SCG_OFF_INT_STAT, 32'h1);
        rd32(`SCG_OFF_INT_STAT, 32'h0, "stat_w1c");
        chk("irq_off", 32'h0, {31'h0, irq});
        @(posedge clk_sys);
        deep_sleep_req <= 1'b0;
        gates(1'b1, 1'b1);
        acc(1'b1, 1'b0, 2'b10);
        rd32(12'h200, 32'h0, "unmapped");
        rd32(`SCG_OFF_INT_STAT, 32'h2, "stat_unmapped");
        chk("irq_unmapped", 32'h1, {31'h0, irq});
        wr32(`SCG_OFF_INT_STAT, 32'h2);
        @(posedge clk_sys);
        sleep_req <= 1'b0;
        gates(1'b1, 1'b0);
        acc(1'b1, 1'b0, 2'b01);
        wr32(`SCG_OFF_RUN_GATE, 32'h8);
        wr32(`SCG_OFF_CFG, 32'h0);
        @(posedge clk_sys);
        deep_sleep_req <= 1'b1;
        gates(1'b0, 1'b1);
        acc(1'b0, 1'b1, 2'b01);
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        gates(1'b1, 1'b0);
        rd32(`SCG_OFF_RUN_GATE, 32'h40, "run_reset");
        rd32(`SCG_OFF_INT_STAT, 32'h0, "stat_reset");
        chk("irq_reset", 32'h0, {31'h0, irq});
        conclude();
    end
endmodule

`default_nettype wire
